/* File: logic/adcsts_params.svh */
`ifndef ADCSTS_PARAMS_SVH
`define ADCSTS_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ADCSTS_CTL0_OFS     12'h000
`define ADCSTS_MODE_OFS     12'h004

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCSTS_CTL0_RST     16'h0000
`define ADCSTS_MODE_RST     1'h0

// ----------------------------------------
// Field positions of converter_control_zero
// ----------------------------------------
`define ADCSTS_UPPER_HI     15
`define ADCSTS_UPPER_LO     12
`define ADCSTS_OUTER_HI     11
`define ADCSTS_OUTER_LO     8
`define ADCSTS_MSC_BIT      7
`define ADCSTS_ON_BIT       4
`define ADCSTS_ENC_BIT      1
`define ADCSTS_SC_BIT       0

// ----------------------------------------
// Field positions of the mode register
// ----------------------------------------
`define ADCSTS_PULSE_BIT    0
`define ADCSTS_BUSY_BIT     1

// ----------------------------------------
// Result entry bounds of the upper group
// ----------------------------------------
`define ADCSTS_UPPER_FIRST  5'h08
`define ADCSTS_UPPER_LAST   5'h17

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADCSTS_CONV_DIV     8'h04
`define ADCSTS_PERIOD_W     11

`endif

/* File: logic/adcsts_pkg.sv */
package adcsts_pkg;

   typedef enum logic [1:0] {
      ADCSTS_IDLE   = 2'b01,
      ADCSTS_SAMPLE = 2'b10
   } adcsts_state_t;

   typedef struct packed {
      adcsts_state_t st;
      logic [15:0]   ctl0;
      logic          pulse_mode;
      logic [7:0]    div;
      logic [10:0]   cnt;
      logic [10:0]   period;
      logic          samp_prev;
      logic          sample_control_signal;
      logic          done;
      logic [31:0]   prdata;
      logic          slverr;
   } adcsts_regs_t;

endpackage

/* File: logic/adcsts_top.sv */
// Contract
// - converter_control_zero at offset zero, sixteen bits, cleared on reset.
// - Bits 15-12 set sample period for result entries 8 to 23.
// - Bits 11-8 set sample period for entries 0-7 and 24-31.
// - Codes 0 to 11 decode 4,8,16,32,64,96,128,192,256,384,512,768 cycles.
// - Codes 12 to 15 all decode to 1024 converter-clock cycles.
// - Sample-time fields may change only while conversion enable is zero.
// - Bit 1 disables converter when zero, enables it when one.
// - Period applies in pulse mode; there sample control comes from the sampling timer, in direct mode from the input.
//
`timescale 1ns/10ps
`include "adcsts_params.svh"

module adcsts_top (
   input  wire logic        i_mclk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_sample_in,
   input  wire logic [4:0]  i_entry_index,
   output logic             o_sample_control,
   output logic             o_sample_done,
   output logic      [10:0] o_sample_cycles,
   output logic             o_conv_enable,
   output logic             o_conv_on,
   output logic             o_multi_sample,
   output logic             o_conv_clk_tick
);

   // ----------------------------------------
   // Sample-time decode
   // ----------------------------------------
   function automatic logic [10:0] adcsts_decode(input logic [3:0] code);
      logic [10:0] cyc;
      cyc = 11'h400;
      case (code)
         4'h0: cyc = 11'h004;
         4'h1: cyc = 11'h008;
         4'h2: cyc = 11'h010;
         4'h3: cyc = 11'h020;
         4'h4: cyc = 11'h040;
         4'h5: cyc = 11'h060;
         4'h6: cyc = 11'h080;
         4'h7: cyc = 11'h0C0;
         4'h8: cyc = 11'h100;
         4'h9: cyc = 11'h180;
         4'hA: cyc = 11'h200;
         4'hB: cyc = 11'h300;
         default: cyc = 11'h400;
      endcase
      return cyc;
   endfunction

   adcsts_pkg::adcsts_regs_t r_reg;
   adcsts_pkg::adcsts_regs_t r_next;

   logic        tick;
   logic        setup;
   logic        wr;
   logic        hit_ctl0;
   logic        hit_mode;
   logic        locked;
   logic        armed;
   logic        rise;
   logic        start_sw;
   logic        upper_sel;
   logic [10:0] sel_period;
   logic [15:0] ctl0_rd;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      r_next   = r_reg;
      r_next.done = 1'b0;
      tick     = (r_reg.div == (`ADCSTS_CONV_DIV - 8'h01));
      setup    = i_psel && !i_penable;
      wr       = i_psel && i_penable && i_pwrite;
      hit_ctl0 = (i_paddr == `ADCSTS_CTL0_OFS);
      hit_mode = (i_paddr == `ADCSTS_MODE_OFS);
      locked   = r_reg.ctl0[`ADCSTS_ENC_BIT];
      armed    = r_reg.ctl0[`ADCSTS_ENC_BIT] && r_reg.ctl0[`ADCSTS_ON_BIT];
      rise     = i_sample_in && !r_reg.samp_prev;
      start_sw = 1'b0;
      ctl0_rd  = r_reg.ctl0;
      ctl0_rd[`ADCSTS_SC_BIT] = 1'b0;

      // Converter clock enable
      r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;

      // Upper group serves entries 8..23, outer group the rest
      upper_sel = (i_entry_index >= `ADCSTS_UPPER_FIRST) &&
                  (i_entry_index <= `ADCSTS_UPPER_LAST);
      if (upper_sel) begin
         sel_period = adcsts_decode(
            r_reg.ctl0[`ADCSTS_UPPER_HI:`ADCSTS_UPPER_LO]);
      end else begin
         sel_period = adcsts_decode(
            r_reg.ctl0[`ADCSTS_OUTER_HI:`ADCSTS_OUTER_LO]);
      end

      // ----------------------------------------
      // Bus read, captured in setup phase
      // ----------------------------------------
      if (setup) begin
         r_next.slverr = !(hit_ctl0 || hit_mode);
         if (hit_ctl0) begin
            r_next.prdata = {16'h0000, ctl0_rd};
         end else if (hit_mode) begin
            r_next.prdata = {30'h00000000, r_reg.sample_control_signal, r_reg.pulse_mode};
         end else begin
            r_next.prdata = 32'h00000000;
         end
      end

      // ----------------------------------------
      // Bus write, taken in access phase
      // ----------------------------------------
      if (wr && hit_ctl0) begin
         if (!locked) begin
            r_next.ctl0[15:8] = i_pwdata[15:8];
            r_next.ctl0[`ADCSTS_MSC_BIT] = i_pwdata[`ADCSTS_MSC_BIT];
            r_next.ctl0[`ADCSTS_ON_BIT]  = i_pwdata[`ADCSTS_ON_BIT];
         end
         r_next.ctl0[`ADCSTS_ENC_BIT] = i_pwdata[`ADCSTS_ENC_BIT];
         // Start may be set in the same write as enable
         start_sw = i_pwdata[`ADCSTS_SC_BIT] &&
                    i_pwdata[`ADCSTS_ENC_BIT] &&
                    r_next.ctl0[`ADCSTS_ON_BIT];
      end
      if (wr && hit_mode && !locked) begin
         r_next.pulse_mode = i_pwdata[`ADCSTS_PULSE_BIT];
      end

      r_next.samp_prev = i_sample_in;

      // ----------------------------------------
      // Sampling timer
      // ----------------------------------------
      case (r_reg.st)
         adcsts_pkg::ADCSTS_IDLE: begin
            if (r_reg.pulse_mode) begin
               r_next.sample_control_signal = 1'b0;
               if ((armed && rise) || start_sw) begin
                  r_next.period  = sel_period;
                  r_next.cnt     = sel_period;
                  r_next.sample_control_signal = 1'b1;
                  r_next.st      = adcsts_pkg::ADCSTS_SAMPLE;
               end
            end else begin
               // Direct mode: input drives sample control
               r_next.sample_control_signal = armed && i_sample_in;
            end
         end
         adcsts_pkg::ADCSTS_SAMPLE: begin
            // A started period always runs out, even if enable drops
            if (tick) begin
               r_next.cnt = r_reg.cnt - 11'h001;
               if (r_reg.cnt == 11'h001) begin
                  r_next.sample_control_signal = 1'b0;
                  r_next.done    = 1'b1;
                  r_next.st      = adcsts_pkg::ADCSTS_IDLE;
               end
            end
         end
         default: begin
            r_next.sample_control_signal = 1'b0;
            r_next.st      = adcsts_pkg::ADCSTS_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         r_reg            <= '0;
         r_reg.st         <= adcsts_pkg::ADCSTS_IDLE;
         r_reg.ctl0       <= `ADCSTS_CTL0_RST;
         r_reg.pulse_mode <= `ADCSTS_MODE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_pready         = i_psel && i_penable;
   assign o_prdata         = r_reg.prdata;
   assign o_pslverr        = r_reg.slverr && i_psel && i_penable;
   assign o_sample_control = r_reg.sample_control_signal;
   assign o_sample_done    = r_reg.done;
   assign o_sample_cycles  = r_reg.period;
   assign o_conv_enable    = r_reg.ctl0[`ADCSTS_ENC_BIT];
   assign o_conv_on        = r_reg.ctl0[`ADCSTS_ON_BIT];
   assign o_multi_sample   = r_reg.ctl0[`ADCSTS_MSC_BIT];
   assign o_conv_clk_tick  = tick;

endmodule

/* File: verif/adcsts_monitor.sv */
`timescale 1ns/10ps
module adcsts_monitor (
   input wire logic        i_mclk,
   input wire logic        i_sys_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pslverr,
   input wire logic        o_sample_control,
   input wire logic        o_sample_done,
   input wire logic [10:0] o_sample_cycles,
   input wire logic        o_conv_enable,
   input wire logic        o_conv_on,
   input wire logic        o_conv_clk_tick
);
   wire acc = i_psel & i_penable;
   wire wr0 = acc & i_pwrite & (i_paddr == 12'h000);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   AST_RESET: assert property ($fell(i_sys_rst) |-> !o_conv_on && !o_conv_enable)
      else $error("control not cleared by reset");
   AST_UNMAP: assert property (acc && i_paddr != 12'h000 && i_paddr != 12'h004
      |-> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
   AST_ENC: assert property (wr0 |=> o_conv_enable == $past(i_pwdata[1]))
      else $error("enable bit not written");
   AST_LOCK: assert property (wr0 && o_conv_enable |=> $stable(o_conv_on))
      else $error("locked bit changed");
   AST_FREE: assert property (wr0 && !o_conv_enable |=> o_conv_on == $past(i_pwdata[4]))
      else $error("unlocked bit not written");
   AST_TICK: assert property (o_conv_clk_tick |=> !o_conv_clk_tick [*3] ##1 o_conv_clk_tick)
      else $error("converter tick spacing");
   AST_DONE: assert property (o_sample_done |-> $fell(o_sample_control) ##1 !o_sample_done)
      else $error("done not at end of sampling");
   AST_PERIOD: assert property (o_sample_done |-> o_sample_cycles inside {11'h004, 11'h008,
      11'h010, 11'h020, 11'h040, 11'h060, 11'h080, 11'h0C0, 11'h100, 11'h180, 11'h200,
      11'h300, 11'h400}) else $error("illegal period");
endmodule

/* File: verif/tb_adc_sample_time_select.sv */
`timescale 1ns/10ps
module tb_adc_sample_time_select;
   logic        i_mclk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
   logic        i_pwrite = 1'b0, i_sample_in = 1'b0, o_pready, o_pslverr, o_sample_control;
   logic        o_sample_done, o_conv_enable, o_conv_on, o_multi_sample, o_conv_clk_tick;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic [4:0]  i_entry_index = 5'h00;
   logic [10:0] o_sample_cycles, n;
   logic [3:0]  up, ot;
   int          bad_count = 0, checks = 0, cyc = 0, hi, k;
   always #5 i_mclk = ~i_mclk;
   adcsts_top DUT (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_sample_in, .i_entry_index, .o_sample_control,
      .o_sample_done, .o_sample_cycles, .o_conv_enable, .o_conv_on, .o_multi_sample,
      .o_conv_clk_tick);
   // 4,8,16,32 / 64,96,128,...,768 / 1024 for 12..15
   function logic [10:0] dec(input logic [3:0] c);
      if (c > 4'hB) dec = 11'h400;
      else if (c < 4'h4) dec = 11'h004 << c;
      else if (c[0]) dec = 11'h003 << ((c + 5'h05) / 2);
      else dec = 11'h001 << ((c + 5'h08) / 2);
   endfunction
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do @(posedge i_mclk); while (o_pready !== 1'b1);
      rd = o_prdata;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task end_of_test;
      if (bad_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Full code sweep needs about 27k cycles
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         end_of_test;
      end
   end
   initial begin
      repeat (12) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h000, 32'h0000AB9D);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000AB90);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0);
      for (k = 0; k < 16; k++) begin
         // Other field holds 15-k so a wrong group pick gives another period
         up = k[0] ? k[3:0] : 4'hF - k[3:0];
         ot = 4'hF - up;
         n = dec(k[3:0]);
         i_entry_index <= k[0] ? (k[1] ? 5'h17 : 5'h08) : (k[1] ? 5'h18 : 5'h07);
         apb(1'b1, 12'h000, {16'h0, up, ot, 8'h10});
         apb(1'b1, 12'h004, 32'h1);
         apb(1'b1, 12'h000, {16'h0, up, ot, 8'h12});
         apb(1'b1, 12'h004, 32'h0);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd, 32'h1);
         if (k[0]) apb(1'b1, 12'h000, {16'h0, up, ot, 8'h13});
         else i_sample_in <= 1'b1;
         hi = 0;
         while (o_sample_done !== 1'b1 && hi < 5000) begin
            @(posedge i_mclk);
            hi++;
         end
         chk({21'h0, o_sample_cycles}, {21'h0, n});
         chk({31'h0, hi >= 4 * n - 4 && hi <= 4 * n + 8}, 32'h1);
         i_sample_in <= 1'b0;
         apb(1'b1, 12'h000, 32'h0);
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, {16'h0, up, ot, 8'h10});
      end
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h00000092);
      i_sample_in <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk({31'h0, o_multi_sample}, 32'h1);
      chk({31'h0, o_sample_control}, 32'h1);
      chk({21'h0, o_sample_cycles}, 32'h400);
      end_of_test;
   end
endmodule
bind adcsts_top adcsts_monitor u_mon (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_prdata, .o_pslverr, .o_sample_control, .o_sample_done,
   .o_sample_cycles, .o_conv_enable, .o_conv_on, .o_conv_clk_tick);
